// ===== src/cpm_phy_mgmt.sv
// Management bridge and paged register file of the copper transceiver
`timescale 1ns/1ns
// Function
// - Registers reached only via management controller zero
// - Sixteen standard registers plus extended set
// - Base space decodes addresses 0 to 31
// - Two extended pages at addresses 16-30
// - General-purpose page at addresses 0-30
// - Clause 45 through registers 13 and 14
// - Page register selects page for 16-30
// - Broadcast enable accepts writes to any address
// - Reads answer only own address
// - Soft reset restores non-sticky base registers; pages and MMD cleared only if stickiness disabled
// - Sticky fields kept unless stickiness disabled
// - Hardware reset restores every register
// - Negotiation resolves speed, duplex, role; partner next page stored in register 8
// - Parallel detection for non-negotiating partner
// - Negotiation off: speed, duplex from control
// - Gigabit needs negotiation except test mode
// - Forced gigabit test mode via force field
// - Crossover and polarity on; disables; status
// - Crossover also at forced 10/100
// - Four pair arrangements handled
// - Manual field forces MDI or MDI-X
module cpm_phy_mgmt (
    input wire logic clock,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input cpm_pkg::cpm_partner_t partner,
    input wire logic [15:0] lpNextPage,
    input wire logic lpNpStrobe,
    input cpm_pkg::cpm_line_t lineDet,
    output cpm_pkg::cpm_mode_t linkMode,
    output cpm_pkg::cpm_xo_t xover
);
    typedef struct packed {
        logic [31:0][15:0] base;
        logic [1:0][15:0][15:0] ext;
        logic [31:0][15:0] gp;
        logic [15:0][15:0] mmd;
        logic [15:0] mmdAddr;
        logic [31:0] cmd;
        cpm_pkg::cpm_miim_t st;
        logic [3:0] div;
        logic [6:0] ticks;
        logic [15:0] rdata;
        logic rdOk;
        logic [5:0] rstCnt;
        logic ack;
        logic [31:0] dat;
        cpm_pkg::cpm_mode_t mode;
        cpm_pkg::cpm_xo_t xo;
    } cpm_state_t;

    localparam int RST_WAIT = cpm_pkg::SOFT_RESET_CYCLES;

    // Default of a base register
    function automatic logic [15:0] baseDefault(input logic [4:0] idx);
        case (idx)
            cpm_pkg::REG_BASIC: return cpm_pkg::BASIC_RST;
            cpm_pkg::REG_ADV: return cpm_pkg::ADV_RST;
            cpm_pkg::REG_GIG_CTRL: return cpm_pkg::GIG_RST;
            cpm_pkg::REG_EXT_CTRL: return cpm_pkg::EXT_CTRL_RST;
            default: return 16'h0000;
        endcase
    endfunction

    // Whole state after hardware reset
    function automatic cpm_state_t resetState();
        cpm_state_t r;
        r = '0;
        for (int i = 0; i < 32; i++) begin
            r.base[i] = baseDefault(5'(i));
        end
        r.st = cpm_pkg::MIIM_IDLE;
        return r;
    endfunction

    localparam cpm_state_t ST_RST = resetState();

    cpm_state_t s;
    cpm_state_t n;

    // Field views of the register file
    logic [15:0] bc;
    logic [15:0] page;
    logic [15:0] gig;
    logic [15:0] bypass;
    logic stickyKeep;
    logic bcast;
    logic [1:0] manual;
    logic forceGig;
    logic [4:0] cReg;
    logic [4:0] cPhy;
    logic [15:0] cData;
    logic pgE1;
    logic pgE2;
    logic pgGp;
    logic extRange;
    logic resetBusy;
    logic [15:0] auxWord;
    cpm_pkg::cpm_mode_t resMode;
    cpm_pkg::cpm_xo_t resXo;

    assign bc = s.base[cpm_pkg::REG_BASIC];
    assign page = s.base[cpm_pkg::REG_PAGE];
    assign gig = s.base[cpm_pkg::REG_GIG_CTRL];
    assign bypass = s.base[cpm_pkg::REG_BYPASS];
    assign stickyKeep = s.base[cpm_pkg::REG_EXT_CTRL][cpm_pkg::EC_STICKY];
    assign bcast = s.base[cpm_pkg::REG_EXT_CTRL][cpm_pkg::EC_BCAST];
    assign manual = s.base[cpm_pkg::REG_EXT_MODE][cpm_pkg::EM_XO_LO +: 2];
    assign forceGig = s.ext[1][cpm_pkg::EXT2_EEE_IDX][cpm_pkg::EEE_FORCE_GIG];
    assign cReg = s.cmd[4:0];
    assign cPhy = s.cmd[9:5];
    assign cData = s.cmd[31:16];
    assign pgE1 = page == cpm_pkg::PAGE_EXT1;
    assign pgE2 = page == cpm_pkg::PAGE_EXT2;
    assign pgGp = page == cpm_pkg::PAGE_GP;
    assign extRange = cReg[4] && (cReg != cpm_pkg::REG_PAGE);
    assign resetBusy = s.rstCnt != 6'h00;

    // Live status word of the auxiliary register
    assign auxWord = {2'h0, s.xo.mdix, s.xo.cdSwap, s.xo.pol, 2'h0,
                      s.mode.duplex, s.mode.speed, 2'h0, s.mode.valid};

    cpm_mode_resolve uResolve (
        .anEnable(bc[cpm_pkg::BC_AN_EN]),
        .speedMsb(bc[cpm_pkg::BC_SPEED_MSB]),
        .speedLsb(bc[cpm_pkg::BC_SPEED_LSB]),
        .fullDuplex(bc[cpm_pkg::BC_DUPLEX]),
        .forceGig(forceGig),
        .localAdv({gig[9], gig[8], s.base[cpm_pkg::REG_ADV][8:5]}),
        .manMsEnable(gig[12]),
        .manMaster(gig[11]),
        .partner(partner),
        .mode(resMode)
    );

    cpm_crossover uCross (
        .anEnable(bc[cpm_pkg::BC_AN_EN]),
        .forcedLowSpeed(!bc[cpm_pkg::BC_SPEED_MSB]),
        .pairSwapDisable(bypass[cpm_pkg::BP_XO_DIS]),
        .forcedSpeedDisable(bypass[cpm_pkg::BP_FS_XO_DIS]),
        .polarityDisable(bypass[cpm_pkg::BP_POL_DIS]),
        .manual(manual),
        .lineDet(lineDet),
        .xo(resXo)
    );

    // Next state: bus slave, management frame, register file
    always_comb begin
        logic [31:0] merged;
        logic [15:0] rd;
        merged = s.cmd;
        rd = 16'h0000;
        n = s;
        n.ack = 1'b0;
        n.mode = resMode;
        n.xo = resXo;
        if (resetBusy) begin
            n.rstCnt = s.rstCnt - 6'h01;
        end
        n.div = (s.div == cpm_pkg::MDC_DIV_LAST) ? 4'h0 : s.div + 4'h1;

        // Read path of the transceiver
        if (cReg == cpm_pkg::REG_PAGE) begin
            rd = page;
        end else if (pgGp) begin
            rd = s.gp[cReg];
        end else if (extRange && (pgE1 || pgE2)) begin
            rd = s.ext[pgE2][cReg[3:0]];
        end else if (cReg == cpm_pkg::REG_AUX) begin
            rd = auxWord;
        end else if (cReg == cpm_pkg::REG_MMD_DATA) begin
            rd = (s.base[cpm_pkg::REG_MMD_CTRL][15:14] == cpm_pkg::MMD_FN_DATA) ?
                 s.mmd[s.mmdAddr[3:0]] : s.mmdAddr;
        end else if (cReg == cpm_pkg::REG_BASIC) begin
            rd = {resetBusy, bc[14:0]};
        end else begin
            rd = s.base[cReg];
        end

        // Management frame sequencing
        unique case (s.st)
            cpm_pkg::MIIM_IDLE: begin
                n.st = cpm_pkg::MIIM_IDLE;
            end
            cpm_pkg::MIIM_FRAME: begin
                if (s.div == cpm_pkg::MDC_DIV_LAST) begin
                    n.ticks = s.ticks + 7'h01;
                    if (s.ticks == cpm_pkg::FRAME_LAST) begin
                        n.st = cpm_pkg::MIIM_DONE;
                        if (!s.cmd[cpm_pkg::CMD_WR]) begin
                            n.rdOk = cPhy == cpm_pkg::OWN_PHY_ADDR;
                            n.rdata = (cPhy == cpm_pkg::OWN_PHY_ADDR) ? rd : 16'hFFFF;
                        end else if ((cPhy == cpm_pkg::OWN_PHY_ADDR || bcast) && !resetBusy) begin
                            if (cReg == cpm_pkg::REG_PAGE) begin
                                n.base[cpm_pkg::REG_PAGE] = cData;
                            end else if (pgGp) begin
                                n.gp[cReg] = cData;
                            end else if (extRange && (pgE1 || pgE2)) begin
                                n.ext[pgE2][cReg[3:0]] = cData;
                            end else if (cReg != cpm_pkg::REG_AUX) begin
                                n.base[cReg] = cData;
                                if (cReg == cpm_pkg::REG_MMD_DATA) begin
                                    if (s.base[cpm_pkg::REG_MMD_CTRL][15:14] == cpm_pkg::MMD_FN_DATA) begin
                                        n.mmd[s.mmdAddr[3:0]] = cData;
                                    end else begin
                                        n.mmdAddr = cData;
                                    end
                                end
                                if (cReg == cpm_pkg::REG_BASIC && cData[cpm_pkg::BC_RESET]) begin
                                    n.rstCnt = cpm_pkg::SOFT_RESET_LOAD;
                                    for (int i = 0; i < 32; i++) begin
                                        if (!cpm_pkg::STICKY_MASK[i] || !stickyKeep) begin
                                            n.base[i] = baseDefault(5'(i));
                                        end
                                    end
                                    if (!stickyKeep) begin
                                        n.ext = '0;
                                        n.gp = '0;
                                        n.mmd = '0;
                                        n.mmdAddr = 16'h0000;
                                    end
                                end
                            end
                        end
                    end
                end
            end
            cpm_pkg::MIIM_DONE: begin
                n.st = cpm_pkg::MIIM_IDLE;
            end
        endcase

        // Partner next page, wins over a same-cycle write or soft reset
        if (lpNpStrobe) begin
            n.base[cpm_pkg::REG_LP_NEXT] = lpNextPage;
        end

        // Wishbone slave, one wait state
        if (cyc_i && stb_i && !s.ack) begin
            n.ack = 1'b1;
            n.dat = 32'h00000000;
            if (adr_i[7:2] == cpm_pkg::WB_MIIM_CMD[7:2]) begin
                if (!we_i) begin
                    n.dat = s.cmd;
                end else if (s.st == cpm_pkg::MIIM_IDLE) begin
                    for (int b = 0; b < 4; b++) begin
                        if (sel_i[b]) begin
                            merged[8 * b +: 8] = dat_i[8 * b +: 8];
                        end
                    end
                    n.cmd = {merged[31:12], 1'b0, merged[10:0]};
                    if (sel_i[1] && dat_i[cpm_pkg::CMD_START]) begin
                        n.st = cpm_pkg::MIIM_FRAME;
                        n.ticks = 7'h00;
                        n.div = 4'h0;
                    end
                end
            end else if (adr_i[7:2] == cpm_pkg::WB_MIIM_STAT[7:2] && !we_i) begin
                n.dat = {14'h0000, s.rdOk, s.st != cpm_pkg::MIIM_IDLE, s.rdata};
            end else if (adr_i[7:2] == cpm_pkg::WB_LINK_STAT[7:2] && !we_i) begin
                n.dat = {16'h0000, auxWord};
            end
        end
    end

    // State register
    always_ff @(posedge clock) begin
        if (rst) begin
            s <= ST_RST;
        end else begin
            s <= n;
        end
    end

    assign dat_o = s.dat;
    assign ack_o = s.ack;
    assign linkMode = s.mode;
    assign xover = s.xo;

    // Checks
    AST_SOFT_RESET_DONE: assert property (@(posedge clock) disable iff (rst)
        $rose(resetBusy) |-> ##RST_WAIT !resetBusy)
        else $error("soft reset bit did not clear in time");

    AST_HW_DEFAULTS: assert property (@(posedge clock)
        rst |=> bc == cpm_pkg::BASIC_RST && s.base[cpm_pkg::REG_EXT_CTRL] == cpm_pkg::EXT_CTRL_RST && s.gp == '0)
        else $error("hardware reset left a register off default");

    AST_SOFT_DEFAULT: assert property (@(posedge clock) disable iff (rst)
        $rose(resetBusy) |-> s.base[cpm_pkg::REG_ADV] == cpm_pkg::ADV_RST && page == 16'h0000)
        else $error("non-sticky field survived soft reset");

    AST_STICKY_KEPT: assert property (@(posedge clock) disable iff (rst)
        $rose(resetBusy) && $past(stickyKeep) |-> bypass == $past(bypass))
        else $error("sticky field lost on soft reset");

    AST_READ_OWN_ONLY: assert property (@(posedge clock) disable iff (rst)
        s.st == cpm_pkg::MIIM_DONE && !s.cmd[cpm_pkg::CMD_WR] && cPhy != cpm_pkg::OWN_PHY_ADDR
        |-> !s.rdOk && s.rdata == 16'hFFFF)
        else $error("read answered for a foreign address");

    AST_BCAST_WRITE: assert property (@(posedge clock) disable iff (rst)
        s.st == cpm_pkg::MIIM_FRAME && n.st == cpm_pkg::MIIM_DONE && s.cmd[cpm_pkg::CMD_WR] && bcast
        && !resetBusy && !pgGp && cReg == cpm_pkg::REG_ADV
        |=> s.base[cpm_pkg::REG_ADV] == $past(cData))
        else $error("broadcast write not accepted");

    AST_FORCED_100: assert property (@(posedge clock) disable iff (rst)
        !bc[cpm_pkg::BC_AN_EN] && !bc[cpm_pkg::BC_SPEED_MSB] && bc[cpm_pkg::BC_SPEED_LSB]
        |=> linkMode.speed == cpm_pkg::SPD_100 && linkMode.duplex == $past(bc[cpm_pkg::BC_DUPLEX]))
        else $error("forced speed not applied");

    AST_GIG_NEEDS_AN: assert property (@(posedge clock) disable iff (rst)
        !bc[cpm_pkg::BC_AN_EN] && bc[cpm_pkg::BC_SPEED_MSB] && !bc[cpm_pkg::BC_SPEED_LSB] && !forceGig
        |=> !linkMode.valid)
        else $error("gigabit forced without test mode");

    AST_MANUAL_XO: assert property (@(posedge clock) disable iff (rst)
        manual[1] |=> xover.mdix == $past(manual[0]) && !xover.cdSwap)
        else $error("manual crossover not honoured");

    AST_FORCED_AUTO_XO: assert property (@(posedge clock) disable iff (rst)
        !bc[cpm_pkg::BC_AN_EN] && !bc[cpm_pkg::BC_SPEED_MSB] && manual == 2'h0
        && bypass[cpm_pkg::BP_FS_XO_DIS] == 1'b0 && !bypass[cpm_pkg::BP_XO_DIS]
        |=> xover.mdix == $past(lineDet.mdix))
        else $error("crossover not automatic at forced speed");

    AST_FORCE_GIG_TEST: assert property (@(posedge clock) disable iff (rst)
        !bc[cpm_pkg::BC_AN_EN] && bc[cpm_pkg::BC_SPEED_MSB] && !bc[cpm_pkg::BC_SPEED_LSB] && forceGig
        |=> linkMode.speed == cpm_pkg::SPD_1000 && linkMode.valid)
        else $error("forced gigabit test mode not entered");

    AST_AUTO_XO_AN: assert property (@(posedge clock) disable iff (rst)
        bc[cpm_pkg::BC_AN_EN] && manual == 2'h0 && !bypass[cpm_pkg::BP_XO_DIS]
        |=> xover.mdix == $past(lineDet.mdix) && xover.cdSwap == $past(lineDet.cdSwap))
        else $error("automatic crossover not applied");
endmodule

// ===== src/cpm_pkg.sv
// Shared constants and types of the copper transceiver management block
package cpm_pkg;
    // Clock and timing
    localparam int CLOCK_NS = 10;
    localparam int SOFT_RESET_NS = 500;
    localparam int SOFT_RESET_CYCLES = (SOFT_RESET_NS + CLOCK_NS - 1) / CLOCK_NS;
    localparam logic [5:0] SOFT_RESET_LOAD = 6'(SOFT_RESET_CYCLES);
    localparam logic [3:0] MDC_DIV_LAST = 4'h9;
    localparam logic [6:0] FRAME_LAST = 7'h3F;

    // Own transceiver address on management controller 0
    localparam logic [4:0] OWN_PHY_ADDR = 5'h00;

    // Wishbone byte offsets
    localparam logic [7:0] WB_MIIM_CMD = 8'h00;
    localparam logic [7:0] WB_MIIM_STAT = 8'h04;
    localparam logic [7:0] WB_LINK_STAT = 8'h08;
    localparam int CMD_WR = 10;
    localparam int CMD_START = 11;

    // Transceiver register addresses
    localparam logic [4:0] REG_BASIC = 5'h00;
    localparam logic [4:0] REG_ADV = 5'h04;
    localparam logic [4:0] REG_LP_NEXT = 5'h08;
    localparam logic [4:0] REG_GIG_CTRL = 5'h09;
    localparam logic [4:0] REG_MMD_CTRL = 5'h0D;
    localparam logic [4:0] REG_MMD_DATA = 5'h0E;
    localparam logic [4:0] REG_BYPASS = 5'h12;
    localparam logic [4:0] REG_EXT_CTRL = 5'h16;
    localparam logic [4:0] REG_EXT_MODE = 5'h17;
    localparam logic [4:0] REG_AUX = 5'h1C;
    localparam logic [4:0] REG_PAGE = 5'h1F;
    localparam logic [3:0] EXT2_EEE_IDX = 4'h1;

    // Page selector codes
    localparam logic [15:0] PAGE_EXT1 = 16'h0001;
    localparam logic [15:0] PAGE_EXT2 = 16'h0002;
    localparam logic [15:0] PAGE_GP = 16'h0010;
    localparam logic [1:0] MMD_FN_DATA = 2'h1;

    // Field positions
    localparam int BC_RESET = 15;
    localparam int BC_SPEED_LSB = 13;
    localparam int BC_AN_EN = 12;
    localparam int BC_DUPLEX = 8;
    localparam int BC_SPEED_MSB = 6;
    localparam int EC_BCAST = 0;
    localparam int EC_STICKY = 1;
    localparam int BP_FS_XO_DIS = 7;
    localparam int BP_XO_DIS = 5;
    localparam int BP_POL_DIS = 4;
    localparam int EM_XO_LO = 2;
    localparam int EEE_FORCE_GIG = 5;

    // Values after reset
    localparam logic [15:0] BASIC_RST = 16'h1140;
    localparam logic [15:0] ADV_RST = 16'h01E1;
    localparam logic [15:0] GIG_RST = 16'h0300;
    localparam logic [15:0] EXT_CTRL_RST = 16'h0002;
    localparam logic [31:0] STICKY_MASK = 32'h00C40000;
    localparam logic [10:0] LOCAL_SEED = 11'h2A5;

    // Pair arrangements, pair index per connector position
    localparam logic [7:0] MAP_MDI = 8'hE4;
    localparam logic [7:0] MAP_MDIX = 8'hB1;
    localparam logic [7:0] MAP_MDI_CD = 8'hB4;
    localparam logic [7:0] MAP_MDIX_CD = 8'hE1;

    typedef enum logic [1:0] {SPD_10 = 2'h0, SPD_100 = 2'h1, SPD_1000 = 2'h2} cpm_speed_t;
    typedef enum logic [1:0] {MIIM_IDLE = 2'h0, MIIM_FRAME = 2'h1, MIIM_DONE = 2'h3} cpm_miim_t;

    typedef struct packed {
        logic anCapable;
        logic [5:0] ability;
        logic [10:0] seed;
        logic detSpeed100;
    } cpm_partner_t;

    typedef struct packed {
        logic mdix;
        logic cdSwap;
        logic [3:0] pol;
    } cpm_line_t;

    typedef struct packed {
        cpm_speed_t speed;
        logic duplex;
        logic master;
        logic valid;
    } cpm_mode_t;

    typedef struct packed {
        logic mdix;
        logic cdSwap;
        logic [3:0] pol;
        logic [7:0] pairMap;
    } cpm_xo_t;
endpackage

// ===== src/cpm_mode_resolve.sv
// Operating mode resolution: negotiation, parallel detection, forced modes
`timescale 1ns/1ns
module cpm_mode_resolve (
    input wire logic anEnable,
    input wire logic speedMsb,
    input wire logic speedLsb,
    input wire logic fullDuplex,
    input wire logic forceGig,
    input wire logic [5:0] localAdv,
    input wire logic manMsEnable,
    input wire logic manMaster,
    input cpm_pkg::cpm_partner_t partner,
    output cpm_pkg::cpm_mode_t mode
);
    // Pick speed, duplex and role
    always_comb begin
        logic [5:0] common;
        common = localAdv & partner.ability;
        mode = '0;
        if (anEnable) begin
            if (partner.anCapable) begin
                mode.valid = common != 6'h00;
                if (common[5] || common[4]) begin
                    mode.speed = cpm_pkg::SPD_1000;
                    mode.duplex = common[5];
                    mode.master = manMsEnable ? manMaster : (cpm_pkg::LOCAL_SEED > partner.seed);
                    mode.valid = manMsEnable || (cpm_pkg::LOCAL_SEED != partner.seed);
                end else if (common[3] || common[2]) begin
                    mode.speed = cpm_pkg::SPD_100;
                    mode.duplex = common[3];
                end else begin
                    mode.speed = cpm_pkg::SPD_10;
                    mode.duplex = common[1];
                end
            end else begin
                // Partner without negotiation
                mode.speed = partner.detSpeed100 ? cpm_pkg::SPD_100 : cpm_pkg::SPD_10;
                mode.valid = partner.detSpeed100 ? (|localAdv[3:2]) : (|localAdv[1:0]);
            end
        end else begin
            mode.duplex = fullDuplex;
            unique case ({speedMsb, speedLsb})
                2'h0: begin
                    mode.speed = cpm_pkg::SPD_10;
                    mode.valid = 1'b1;
                end
                2'h1: begin
                    mode.speed = cpm_pkg::SPD_100;
                    mode.valid = 1'b1;
                end
                2'h2: begin
                    mode.speed = cpm_pkg::SPD_1000;
                    mode.valid = forceGig;
                end
                2'h3: begin
                    mode.valid = 1'b0;
                end
            endcase
        end
    end
endmodule

// ===== src/cpm_crossover.sv
// Crossover and polarity selection for the four twisted pairs
`timescale 1ns/1ns
module cpm_crossover (
    input wire logic anEnable,
    input wire logic forcedLowSpeed,
    input wire logic pairSwapDisable,
    input wire logic forcedSpeedDisable,
    input wire logic polarityDisable,
    input wire logic [1:0] manual,
    input cpm_pkg::cpm_line_t lineDet,
    output cpm_pkg::cpm_xo_t xo
);
    // Manual setting first, then automatic detection
    always_comb begin
        logic autoOk;
        autoOk = !pairSwapDisable && (anEnable || (forcedLowSpeed && !forcedSpeedDisable));
        xo = '0;
        case (manual)
            2'h2: begin
                xo.mdix = 1'b0;
            end
            2'h3: begin
                xo.mdix = 1'b1;
            end
            default: begin
                xo.mdix = autoOk && lineDet.mdix;
                xo.cdSwap = autoOk && lineDet.cdSwap;
            end
        endcase
        xo.pol = polarityDisable ? 4'h0 : lineDet.pol;
        unique case ({xo.mdix, xo.cdSwap})
            2'h0: xo.pairMap = cpm_pkg::MAP_MDI;
            2'h1: xo.pairMap = cpm_pkg::MAP_MDI_CD;
            2'h2: xo.pairMap = cpm_pkg::MAP_MDIX;
            2'h3: xo.pairMap = cpm_pkg::MAP_MDIX_CD;
        endcase
    end
endmodule

// ===== bench/cpm_link_partner.sv
// Link partner and line detector model for the transceiver
`timescale 1ns/1ns
module cpm_link_partner (
    input wire logic clock,
    output cpm_pkg::cpm_partner_t partner,
    output logic [15:0] lpNextPage,
    output logic lpNpStrobe,
    output cpm_pkg::cpm_line_t lineDet
);
    logic [7:0] tick = 8'h00;
    // Negotiating partner, all abilities, seed below ours
    initial begin
        partner = '{1'b1, 6'h3F, 11'h100, 1'b1};
        lineDet = '{1'b1, 1'b1, 4'h5};
    end
    // Next page word at tick 64, repeated every 256 clocks as tick wraps
    always @(posedge clock) begin
        tick <= tick + 8'h01;
        lpNpStrobe <= (tick == 8'h40);
        lpNextPage <= 16'hA55A;
    end
endmodule

// ===== bench/testbench.sv
// Self-checking bench of the transceiver management block
`timescale 1ns/1ns
module testbench;
    logic clock, rst, cyc, stb, we, ack, npStrobe;
    logic [7:0] adr;
    logic [31:0] wdat, rdat, r;
    logic [15:0] nextPage;
    cpm_pkg::cpm_partner_t partner;
    cpm_pkg::cpm_line_t lineDet;
    cpm_pkg::cpm_mode_t linkMode;
    cpm_pkg::cpm_xo_t xover;
    int mismatches = 0;
    int checks = 0;
    // Clock
    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    cpm_phy_mgmt i_dut (.clock(clock), .rst(rst), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr),
        .sel_i(4'hF), .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .partner(partner),
        .lpNextPage(nextPage), .lpNpStrobe(npStrobe), .lineDet(lineDet), .linkMode(linkMode), .xover(xover));
    cpm_link_partner i_partner (.clock(clock), .partner(partner), .lpNextPage(nextPage),
        .lpNpStrobe(npStrobe), .lineDet(lineDet));
    task automatic report_and_stop();
        $display("TB: checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Classic single cycle, held until ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clock);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) mismatches++;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clock);
    endtask
    // Management frame, then poll until not busy
    task automatic mi(input logic w, input logic [4:0] pa, input logic [4:0] ra, input logic [15:0] d);
        int n;
        n = 0;
        wb(1'b1, 8'h00, {d, 4'h0, 1'b1, w, pa, ra}, r);
        do begin
            wb(1'b0, 8'h04, 32'h0, r);
            n++;
        end while (r[16] !== 1'b0 && n < 800);
        if (n >= 800) mismatches++;
        r = r & 32'h3FFFF;
    endtask
    task automatic pw(input logic [4:0] ra, input logic [15:0] d);
        mi(1'b1, 5'h00, ra, d);
    endtask
    task automatic pr(input logic [4:0] ra, input logic [15:0] e);
        mi(1'b0, 5'h00, ra, 16'h0);
        chk(r, {14'h0, 2'b10, e});
    endtask
    initial begin
        #400000;
        mismatches++;
        report_and_stop();
    end
    initial begin
        {cyc, stb, we, adr, wdat} = '0;
        rst = 1'b1;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        pr(5'h00, 16'h1140);
        pr(5'h16, 16'h0002);
        pr(5'h08, 16'hA55A);
        mi(1'b0, 5'h03, 5'h00, 16'h0);
        chk(r, 32'h0FFFF);
        chk(32'(linkMode), {27'h0, cpm_pkg::SPD_1000, 3'b111});
        chk(32'(xover.pairMap), 32'(cpm_pkg::MAP_MDIX_CD));
        wb(1'b0, 8'h08, 32'h0, r);
        chk(32'(r[13]), 32'h1);
        pw(5'h17, 16'h0008);
        chk(32'(xover.mdix), 32'h0);
        pw(5'h17, 16'h000C);
        chk(32'(xover.mdix), 32'h1);
        pw(5'h16, 16'h0003);
        mi(1'b1, 5'h03, 5'h04, 16'h0061);
        pr(5'h04, 16'h0061);
        pw(5'h12, 16'h0020);
        pw(5'h00, 16'h9140);
        pr(5'h00, 16'h1140);
        pr(5'h04, 16'h01E1);
        pr(5'h12, 16'h0020);
        pw(5'h16, 16'h0000);
        pw(5'h00, 16'h9140);
        pr(5'h12, 16'h0000);
        pw(5'h1F, 16'h0001);
        pw(5'h10, 16'h1234);
        pr(5'h10, 16'h1234);
        pw(5'h1F, 16'h0000);
        pr(5'h10, 16'h0000);
        pw(5'h0D, 16'h0003);
        pw(5'h0E, 16'h0005);
        pw(5'h0D, 16'h4003);
        pw(5'h0E, 16'hBEEF);
        pr(5'h0E, 16'hBEEF);
        pw(5'h00, 16'h2100);
        chk({linkMode.speed, linkMode.duplex, linkMode.valid}, {28'h0, cpm_pkg::SPD_100, 2'b11});
        pw(5'h00, 16'h0140);
        chk(32'(linkMode.valid), 32'h0);
        pw(5'h1F, 16'h0002);
        pw(5'h11, 16'h0020);
        chk({linkMode.speed, linkMode.valid}, {29'h0, cpm_pkg::SPD_1000, 1'b1});
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        @(posedge clock);
        pr(5'h1F, 16'h0000);
        pw(5'h1F, 16'h0002);
        pr(5'h11, 16'h0000);
        report_and_stop();
    end
endmodule
